// ### src/ccs_pkg.sv
package ccs_pkg;
  // ****************************************
  // Register map (word-aligned byte addresses)
  // ****************************************
  localparam logic [3:0]  CCS_ADDR_CORE_CONTROL = 4'h0;
  localparam logic [3:0]  CCS_ADDR_CTX_STATUS   = 4'h4;
  localparam logic [3:0]  CCS_ADDR_PRIORITY     = 4'h8;
  localparam logic [3:0]  CCS_ADDR_CTX_SWITCH   = 4'hc;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CCS_BIT_MULT_MODE   = 0;
  localparam int CCS_BIT_ROUNDING    = 1;
  localparam int CCS_BIT_STACK_FRAME = 2;
  localparam int CCS_BIT_PRIO_EXT    = 3;
  localparam int CCS_CUR_CTX_LSB     = 8;
  localparam int CCS_MAN_CTX_LSB     = 0;
  localparam int CCS_BIT_SWITCH_MAN  = 3;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [15:0] CCS_CORE_CONTROL_RST = 16'h0000;
  localparam logic [2:0]  CCS_CTX_DEFAULT      = 3'h0;
  localparam logic [2:0]  CCS_CTX_MAX          = 3'h4;
  localparam logic [7:0]  CCS_BASE_PAGE        = 8'h01;
  localparam logic [31:0] CCS_UNMAPPED_DATA    = 32'h0000_0000;

  typedef enum logic {CCS_ROUND_CONVERGENT, CCS_ROUND_BIASED} ccs_round_t;
  typedef enum logic {CCS_MULT_FRACTIONAL, CCS_MULT_INTEGER} ccs_mult_t;

  typedef struct packed {
    logic       stack_frame_active;
    ccs_round_t rounding_select;
    ccs_mult_t  mult_mode;
    logic [3:0] cpu_priority_level;
  } ccs_core_cfg_t;

  typedef struct packed {
    logic [2:0] current_context_id;
    logic [2:0] manual_context_id;
  } ccs_ctx_t;
endpackage

// ### src/ccs_core_control.sv
// How it works
// - Stack frame active: frame and stack pointers full range
// - Stack frame clear: pointers use base data space
// - Rounding bit one biased, zero convergent rounding
// - Multiplier bit one integer, zero fractional mode
// - Priority level is extension bit over status bits
// - Bits ten to eight report current register set
// - Bits two to zero report last manual set
// - Unimplemented context status bits always read zero
// - Context fields read-only, zero after reset
`timescale 1ns/1ps
`default_nettype none
module ccs_core_control
  import ccs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // CPU side
  input  wire logic [2:0]  i_cpu_priority_bits,
  input  wire logic        i_ctx_switch,
  input  wire logic [2:0]  i_ctx_switch_id,
  input  wire logic        i_ctx_switch_manual,
  input  wire logic [7:0]  i_data_read_page,
  input  wire logic [15:0] i_frame_pointer_reg,
  input  wire logic [15:0] i_stack_pointer_reg,
  output ccs_core_cfg_t    o_core_cfg,
  output ccs_ctx_t         o_ctx,
  output logic [23:0]      o_frame_pointer_ea,
  output logic [23:0]      o_stack_pointer_ea
);

  // ****************************************
  // Bus handshake
  // ****************************************
  // Every access is answered one cycle after it is presented, so the read
  // data are already registered when waitrequest drops.
  logic        ack_q;
  logic        stack_frame_q;
  logic        rounding_q;
  logic        mult_mode_q;
  logic        prio_ext_q;
  logic [2:0]  cur_ctx_q;
  logic [2:0]  man_ctx_q;
  logic [31:0] rdata_q;
  logic [15:0] core_word;
  logic [15:0] ctx_word;
  logic        req;
  logic        wr_take;
  logic        sw_valid;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_take           = i_avs_write & ack_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ****************************************
  // Core control bits
  // ****************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stack_frame_q <= CCS_CORE_CONTROL_RST[CCS_BIT_STACK_FRAME];
      rounding_q    <= CCS_CORE_CONTROL_RST[CCS_BIT_ROUNDING];
      mult_mode_q   <= CCS_CORE_CONTROL_RST[CCS_BIT_MULT_MODE];
      prio_ext_q    <= CCS_CORE_CONTROL_RST[CCS_BIT_PRIO_EXT];
    end else if (wr_take && i_avs_address == CCS_ADDR_CORE_CONTROL && i_avs_byteenable[0]) begin
      stack_frame_q <= i_avs_writedata[CCS_BIT_STACK_FRAME];
      rounding_q    <= i_avs_writedata[CCS_BIT_ROUNDING];
      mult_mode_q   <= i_avs_writedata[CCS_BIT_MULT_MODE];
      prio_ext_q    <= i_avs_writedata[CCS_BIT_PRIO_EXT];
    end
  end

  assign o_core_cfg.stack_frame_active = stack_frame_q;
  assign o_core_cfg.rounding_select    = rounding_q ? CCS_ROUND_BIASED : CCS_ROUND_CONVERGENT;
  assign o_core_cfg.mult_mode          = mult_mode_q ? CCS_MULT_INTEGER : CCS_MULT_FRACTIONAL;
  assign o_core_cfg.cpu_priority_level = {prio_ext_q, i_cpu_priority_bits};

  // ****************************************
  // Pointer addressing
  // ****************************************
  // The effective address carries an 8-bit page above the 16-bit offset.
  // The page is zero in both modes and the read page is ignored; with the
  // frame active the whole 16-bit offset range is reachable.
  always_comb begin
    if (stack_frame_q) begin
      o_frame_pointer_ea = {8'h00, i_frame_pointer_reg};
      o_stack_pointer_ea = {8'h00, i_stack_pointer_reg};
    end else begin
      o_frame_pointer_ea = {8'h00, 1'b0, i_frame_pointer_reg[14:0]};
      o_stack_pointer_ea = {8'h00, 1'b0, i_stack_pointer_reg[14:0]};
    end
  end

  // ****************************************
  // Context tracking
  // ****************************************
  // Switches to reserved identifiers are dropped; software cannot write here.
  assign sw_valid = i_ctx_switch && (i_ctx_switch_id <= CCS_CTX_MAX);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_ctx_q <= CCS_CTX_DEFAULT;
    end else if (sw_valid) begin
      cur_ctx_q <= i_ctx_switch_id;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      man_ctx_q <= CCS_CTX_DEFAULT;
    end else if (sw_valid && i_ctx_switch_manual) begin
      man_ctx_q <= i_ctx_switch_id;
    end
  end

  assign o_ctx.current_context_id = cur_ctx_q;
  assign o_ctx.manual_context_id  = man_ctx_q;

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    core_word                      = 16'h0000;
    core_word[CCS_BIT_STACK_FRAME] = stack_frame_q;
    core_word[CCS_BIT_ROUNDING]    = rounding_q;
    core_word[CCS_BIT_MULT_MODE]   = mult_mode_q;
    core_word[CCS_BIT_PRIO_EXT]    = prio_ext_q;
    ctx_word                       = 16'h0000;
    ctx_word[CCS_CUR_CTX_LSB +: 3] = cur_ctx_q;
    ctx_word[CCS_MAN_CTX_LSB +: 3] = man_ctx_q;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      if (i_avs_address == CCS_ADDR_CORE_CONTROL) begin
        rdata_q <= {16'h0000, core_word};
      end else if (i_avs_address == CCS_ADDR_CTX_STATUS) begin
        rdata_q <= {16'h0000, ctx_word};
      end else if (i_avs_address == CCS_ADDR_PRIORITY) begin
        rdata_q <= {28'h0000000, prio_ext_q, i_cpu_priority_bits};
      end else begin
        rdata_q <= CCS_UNMAPPED_DATA;
      end
    end
  end

  assign o_avs_readdata = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  frame_full_range_a: assert property (stack_frame_q |->
    o_stack_pointer_ea == {8'h00, i_stack_pointer_reg}) else $error("full range lost");
  frame_base_space_a: assert property (!stack_frame_q |->
    o_frame_pointer_ea[23:15] == 9'h000) else $error("frame left base space");
  rounding_write_a: assert property (wr_take && i_avs_address == CCS_ADDR_CORE_CONTROL
    && i_avs_byteenable[0] |=> o_core_cfg.rounding_select == ccs_round_t'(
    $past(i_avs_writedata[CCS_BIT_ROUNDING]))) else $error("rounding not taken");
  mult_write_a: assert property (wr_take && i_avs_address == CCS_ADDR_CORE_CONTROL
    && i_avs_byteenable[0] |=> o_core_cfg.mult_mode == ccs_mult_t'(
    $past(i_avs_writedata[CCS_BIT_MULT_MODE]))) else $error("mult mode not taken");
  priority_concat_a: assert property (o_core_cfg.cpu_priority_level[2:0]
    == i_cpu_priority_bits && o_core_cfg.cpu_priority_level[3] == prio_ext_q)
    else $error("priority level wrong");
  ctx_switch_a: assert property (sw_valid |=>
    o_ctx.current_context_id == $past(i_ctx_switch_id)) else $error("switch missed");
  manual_ctx_a: assert property (!(sw_valid && i_ctx_switch_manual) |=>
    $stable(man_ctx_q)) else $error("manual id moved");
  ctx_range_a: assert property (cur_ctx_q <= CCS_CTX_MAX && man_ctx_q <= CCS_CTX_MAX)
    else $error("context id out of range");
  ctx_read_zero_a: assert property (i_avs_read && !ack_q
    && i_avs_address == CCS_ADDR_CTX_STATUS |=> rdata_q[31:11] == 21'h0
    && rdata_q[7:3] == 5'h00) else $error("reserved bits set");
  wait_bound_a: assert property (req |-> ##[0:1] !o_avs_waitrequest)
    else $error("bus stalled");

  // ****************************************
  // Pointer addressing checks
  // ****************************************
  // Both pointers are watched in both modes, so a slip in either arm of
  // the mux is caught even when only one pointer is in use.
  frame_fp_full_a: assert property (
    stack_frame_q
    |-> o_frame_pointer_ea == {8'h00, i_frame_pointer_reg})
    else $error("frame pointer range lost");
  stack_base_space_a: assert property (
    !stack_frame_q
    |-> o_stack_pointer_ea[23:15] == 9'h000)
    else $error("stack left base space");
  fp_offset_kept_a: assert property (
    !stack_frame_q
    |-> o_frame_pointer_ea[14:0] == i_frame_pointer_reg[14:0])
    else $error("frame offset lost");
  sp_offset_kept_a: assert property (
    !stack_frame_q
    |-> o_stack_pointer_ea[14:0] == i_stack_pointer_reg[14:0])
    else $error("stack offset lost");

  // ****************************************
  // Core control checks
  // ****************************************
  // A write counts only when it lands on the control word with lane 0
  // enabled; every other cycle must leave the mode bits alone.
  logic core_wr;
  assign core_wr = wr_take && i_avs_address == CCS_ADDR_CORE_CONTROL && i_avs_byteenable[0];

  frame_write_a: assert property (
    core_wr
    |=> stack_frame_q == $past(i_avs_writedata[CCS_BIT_STACK_FRAME]))
    else $error("frame bit not taken");
  frame_hold_a: assert property (
    !core_wr
    |=> $stable(stack_frame_q))
    else $error("frame bit moved");
  round_hold_a: assert property (
    !core_wr
    |=> $stable(rounding_q))
    else $error("rounding bit moved");
  mult_hold_a: assert property (
    !core_wr
    |=> $stable(mult_mode_q))
    else $error("mult bit moved");
  prio_ext_write_a: assert property (
    core_wr
    |=> prio_ext_q == $past(i_avs_writedata[CCS_BIT_PRIO_EXT]))
    else $error("priority extension not taken");
  prio_ext_hold_a: assert property (
    !core_wr
    |=> $stable(prio_ext_q))
    else $error("priority extension moved");

  // ****************************************
  // Context checks
  // ****************************************
  // Reserved identifiers must leave both fields untouched; a software
  // write to the status word must never reach them either.
  cur_ctx_hold_a: assert property (
    !sw_valid
    |=> $stable(cur_ctx_q))
    else $error("current id moved");
  reserved_drop_a: assert property (
    i_ctx_switch && i_ctx_switch_id > CCS_CTX_MAX
    |=> $stable(cur_ctx_q) && $stable(man_ctx_q))
    else $error("reserved id taken");
  manual_take_a: assert property (
    sw_valid && i_ctx_switch_manual
    |=> man_ctx_q == $past(i_ctx_switch_id))
    else $error("manual id not taken");
  ctx_write_ignored_a: assert property (
    i_avs_write && i_avs_address == CCS_ADDR_CTX_STATUS && !i_ctx_switch
    |=> $stable(cur_ctx_q) && $stable(man_ctx_q))
    else $error("context written by software");

  // ****************************************
  // Read data checks
  // ****************************************
  // Read data are captured in the first cycle of a read and must then
  // stand untouched until the next read begins.
  ctx_read_value_a: assert property (
    i_avs_read && !ack_q && i_avs_address == CCS_ADDR_CTX_STATUS
    |=> rdata_q[10:8] == $past(cur_ctx_q) && rdata_q[2:0] == $past(man_ctx_q))
    else $error("context read wrong");
  core_read_value_a: assert property (
    i_avs_read && !ack_q && i_avs_address == CCS_ADDR_CORE_CONTROL
    |=> rdata_q == {28'h0000000, $past(prio_ext_q), $past(stack_frame_q),
    $past(rounding_q), $past(mult_mode_q)})
    else $error("control read wrong");
  prio_read_a: assert property (
    i_avs_read && !ack_q && i_avs_address == CCS_ADDR_PRIORITY
    |=> rdata_q[3:0] == {$past(prio_ext_q), $past(i_cpu_priority_bits)})
    else $error("priority read wrong");
  upper_zero_a: assert property (
    i_avs_read && !ack_q
    |=> rdata_q[31:16] == 16'h0000)
    else $error("upper half set");
  rdata_hold_a: assert property (
    !(i_avs_read && !ack_q)
    |=> $stable(rdata_q))
    else $error("read data moved");

  // ****************************************
  // Handshake checks
  // ****************************************
  // Exactly one wait cycle: the first cycle of a request always waits and
  // the acknowledge never stands for two cycles in a row.
  wait_first_a: assert property (
    req && !ack_q
    |-> o_avs_waitrequest)
    else $error("no wait cycle");
  ack_single_a: assert property (
    ack_q
    |=> !ack_q)
    else $error("acknowledge stuck");
  ack_needs_req_a: assert property (
    !req
    |=> !ack_q)
    else $error("acknowledge without request");

  reserved_sw_c: cover property (i_ctx_switch && i_ctx_switch_id > CCS_CTX_MAX);
  frame_active_c: cover property (stack_frame_q && !o_avs_waitrequest && i_avs_read);

  read_ctx_c: cover property (i_avs_read && !o_avs_waitrequest
    && i_avs_address == CCS_ADDR_CTX_STATUS && rdata_q[10:8] != 3'h0);
  write_core_c: cover property (wr_take && i_avs_address == CCS_ADDR_CORE_CONTROL);
  manual_sw_c: cover property (sw_valid && i_ctx_switch_manual);

endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccs_pkg::*;
  // ****************************************
  // Stimulus and design
  // ****************************************
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [3:0]    adr = 4'h0;
  logic          rd  = 1'b0;
  logic          wr  = 1'b0;
  logic [31:0]   wd  = 32'h0;
  logic [31:0]   rdd;
  logic          wait_rq;
  logic [2:0]    pr  = 3'h0;
  logic          sw  = 1'b0;
  logic [2:0]    sid = 3'h0;
  logic          sman = 1'b0;
  logic [15:0]   fp  = 16'hf0a5;
  logic [15:0]   sp  = 16'h8c3e;
  ccs_core_cfg_t cfg;
  ccs_ctx_t      ctx;
  logic [23:0]   fea;
  logic [23:0]   sea;
  int            fail_count = 0;
  int            n_compared = 0;
  int            cyc = 0;
  logic [31:0]   q;
  logic [2:0]    cur;
  logic [2:0]    man;
  ccs_core_control dut (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdd),
    .o_avs_waitrequest(wait_rq), .i_cpu_priority_bits(pr), .i_ctx_switch(sw),
    .i_ctx_switch_id(sid), .i_ctx_switch_manual(sman), .i_data_read_page(8'ha5),
    .i_frame_pointer_reg(fp), .i_stack_pointer_reg(sp), .o_core_cfg(cfg), .o_ctx(ctx),
    .o_frame_pointer_ea(fea), .o_stack_pointer_ea(sea));
  initial begin
    forever #20 clk = ~clk;
  end
  // A hang in a bus wait is caught here rather than in each task.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      end_sim();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    @(posedge clk iff wait_rq === 1'b0);
    q = rdd;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, CCS_ADDR_CORE_CONTROL, 32'h0);
    chk("core reset", 32'h0, q);
    bus(1'b0, CCS_ADDR_CTX_STATUS, 32'h0);
    chk("ctx reset", 32'h0, q);
    $display("test reset done");
    for (int v = 0; v < 16; v++) begin
      pr <= v[2:0] ^ 3'h5;
      bus(1'b1, CCS_ADDR_CORE_CONTROL, 32'(v));
      bus(1'b0, CCS_ADDR_CORE_CONTROL, 32'h0);
      chk("core read", 32'(v), q);
      chk("mode bits", 32'(v[2:0]), 32'({cfg.stack_frame_active, cfg.rounding_select,
        cfg.mult_mode}));
      chk("prio level", 32'({v[3], v[2:0] ^ 3'h5}), 32'(cfg.cpu_priority_level));
      bus(1'b0, CCS_ADDR_PRIORITY, 32'h0);
      chk("prio read", 32'({v[3], v[2:0] ^ 3'h5}), q);
      chk("fp ea", v[2] ? 32'(fp) : 32'(fp[14:0]), 32'(fea));
      chk("sp ea", v[2] ? 32'(sp) : 32'(sp[14:0]), 32'(sea));
    end
    $display("test core control done");
    cur = 3'h0;
    man = 3'h0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      sw   <= 1'b1;
      sid  <= k[2:0];
      sman <= k[3];
      @(posedge clk);
      sw <= 1'b0;
      if (k[2:0] <= 3'h4) cur = k[2:0];
      if (k[2:0] <= 3'h4 && k[3]) man = k[2:0];
      bus(1'b0, CCS_ADDR_CTX_STATUS, 32'h0);
      chk("ctx read", {21'h0, cur, 5'h0, man}, q);
      chk("ctx port", 32'({cur, man}), 32'(ctx));
    end
    bus(1'b1, CCS_ADDR_CTX_STATUS, 32'hffff_ffff);
    bus(1'b0, CCS_ADDR_CTX_STATUS, 32'h0);
    chk("ctx write", {21'h0, cur, 5'h0, man}, q);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", CCS_UNMAPPED_DATA, q);
    $display("test context done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, CCS_ADDR_CTX_STATUS, 32'h0);
    chk("ctx after reset", 32'h0, q);
    bus(1'b0, CCS_ADDR_CORE_CONTROL, 32'h0);
    chk("core after reset", 32'h0, q);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
